// ===== wake_cfg.svh
// Offsets, field positions and reset values of the wake status and enable register bank
`ifndef WAKE_CFG_SVH
`define WAKE_CFG_SVH

// Register indices; byte address is four times the index
`define WAKE_IDX_MASTER 6'h02
`define WAKE_IDX_STS4 6'h07
`define WAKE_IDX_STS5 6'h08
`define WAKE_IDX_RSVD 6'h09
`define WAKE_IDX_EN1 6'h0A

// Reset values and writable masks
`define WAKE_RST_BYTE 8'h00
`define WAKE_RST_WORD 32'h0000_0000
`define WAKE_MASTER_WMASK 8'h01
`define WAKE_EN1_WMASK 8'hFE

// Field positions inside enable one and the master wake enable
`define WAKE_EN1_RSVD_BIT 0
`define WAKE_EN1_RING_TWO_BIT 1
`define WAKE_EN1_RING_ONE_BIT 2
`define WAKE_EN1_KEYBOARD_BIT 3
`define WAKE_EN1_MOUSE_BIT 4
`define WAKE_EN1_SPECIFIC_KEY_BIT 5
`define WAKE_EN1_FAN_ONE_BIT 6
`define WAKE_EN1_FAN_TWO_BIT 7
`define WAKE_MASTER_BIT 0

`endif

// ===== wake_pkg.sv
// Types shared by the wake status and enable register bank
package wake_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] reg_idx_t;
  typedef logic [15:0] wake_pins_t;
endpackage

// ===== wake_sync.sv
// Two-flop synchroniser for the sixteen general-purpose wake pins
`timescale 1ns/1ps
module wake_sync
  import wake_pkg::*;
(
  input logic ref_clk,
  input logic srst,
  input wake_pins_t pins_async,
  output wake_pins_t pins_sync
);
  wake_pins_t meta_q;
  wake_pins_t sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= 16'h0000;
      sync_q <= 16'h0000;
    end else begin
      meta_q <= pins_async;
      sync_q <= meta_q;
    end
  end

  assign pins_sync = sync_q;
endmodule

// ===== wake_status_byte.sv
// One sticky write-one-to-clear wake status byte with rising-edge event capture
`timescale 1ns/1ps
`include "wake_cfg.svh"
module wake_status_byte
  import wake_pkg::*;
(
  input logic ref_clk,
  input logic srst,
  input reg_byte_t src_sync,
  input reg_byte_t clr_mask,
  output reg_byte_t status
);
  reg_byte_t prev_q;
  reg_byte_t sts_q;
  reg_byte_t rise;
  reg_byte_t sts_d;

  // Event is a rising edge of the synchronised source; set beats a same-cycle clear
  assign rise = src_sync & ~prev_q;
  assign sts_d = (sts_q & ~clr_mask) | rise;

  // The standby power-on reset clears the byte and its edge history
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_q <= `WAKE_RST_BYTE;
      sts_q <= `WAKE_RST_BYTE;
    end else begin
      prev_q <= src_sync;
      sts_q <= sts_d;
    end
  end

  assign status = sts_q;

  // Event captured whatever the enables hold
  event_sets_a: assert property (@(posedge ref_clk) disable iff (srst)
    (rise != 8'h00) |=> ((sts_q & $past(rise)) == $past(rise)))
    else $error("wake event not captured in status");

  // Write of one clears a bit that sees no new event
  one_clears_a: assert property (@(posedge ref_clk) disable iff (srst)
    ((clr_mask & ~rise) != 8'h00) |=> ((sts_q & $past(clr_mask & ~rise)) == 8'h00))
    else $error("status bit not cleared by write of one");

  // Bits neither cleared nor set hold their value
  zero_keeps_a: assert property (@(posedge ref_clk) disable iff (srst)
    1'b1 |=> ((sts_q & ~$past(clr_mask | rise)) == ($past(sts_q) & ~$past(clr_mask | rise))))
    else $error("status bit changed without cause");

  // Standby reset empties the byte
  reset_clears_a: assert property (@(posedge ref_clk)
    srst |=> (sts_q == 8'h00))
    else $error("status not zero after standby reset");

  set_and_clear_c: cover property (@(posedge ref_clk) disable iff (srst)
    (rise & clr_mask) != 8'h00);
endmodule

// ===== pme_wake_status_enable_regs.sv
// Wishbone register bank for wake status four and five, enable one and the master wake enable
`timescale 1ns/1ps
`include "wake_cfg.svh"
module pme_wake_status_enable_regs
  import wake_pkg::*;
(
  input logic ref_clk,
  input logic srst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic [7:0] wake_pins_four,
  input logic [7:0] wake_pins_five,
  input reg_byte_t status_one_in,
  input reg_byte_t enable_four_in,
  input reg_byte_t enable_five_in,
  output logic wake_request_n
);

  // Index decode shared by the read mux and the write strobes
  function automatic logic idx_hit(input logic [7:0] adr, input reg_idx_t idx);
    idx_hit = (adr[7:2] == idx);
  endfunction

  // Bus state
  logic ack_q;
  logic [31:0] dat_q;

  // Register state
  logic master_q;
  reg_byte_t en1_q;
  logic req_n_q;

  // Status bytes and synchronised pins
  reg_byte_t sts4;
  reg_byte_t sts5;
  wake_pins_t pins_sync;
  reg_byte_t pins_four_sync;
  reg_byte_t pins_five_sync;

  // Decode and strobes
  logic req;
  logic take;
  logic commit_wr;
  logic byte0_wr;
  logic hit_master;
  logic hit_sts4;
  logic hit_sts5;
  logic hit_rsvd;
  logic hit_en1;
  reg_byte_t rd_byte;
  reg_byte_t wr_byte;
  reg_byte_t clr4;
  reg_byte_t clr5;
  reg_byte_t en1_d;
  logic master_d;

  // Wake request terms
  reg_byte_t armed_one;
  reg_byte_t armed_four;
  reg_byte_t armed_five;
  logic wake_pending;

  // Pins pass two flops before any logic looks at them
  wake_sync u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pins_async({wake_pins_five, wake_pins_four}),
    .pins_sync(pins_sync)
  );

  // Low byte carries status four sources, high byte status five sources
  assign pins_four_sync = pins_sync[7:0];
  assign pins_five_sync = pins_sync[15:8];

  // Status four: bit order 30,31,32,33,41,43,60,61 as wired by the caller
  wake_status_byte u_sts4 (
    .ref_clk(ref_clk),
    .srst(srst),
    .src_sync(pins_four_sync),
    .clr_mask(clr4),
    .status(sts4)
  );

  // Status five: bit n is pin 50 plus n
  wake_status_byte u_sts5 (
    .ref_clk(ref_clk),
    .srst(srst),
    .src_sync(pins_five_sync),
    .clr_mask(clr5),
    .status(sts5)
  );

  // Wishbone classic handshake terms
  assign req = wb_cyc_i & wb_stb_i;
  assign take = req & ~ack_q;
  assign commit_wr = req & ack_q & wb_we_i;
  assign byte0_wr = commit_wr & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  // Address decode; everything else is unmapped and reads zero
  assign hit_master = idx_hit(wb_adr_i, `WAKE_IDX_MASTER);
  assign hit_sts4 = idx_hit(wb_adr_i, `WAKE_IDX_STS4);
  assign hit_sts5 = idx_hit(wb_adr_i, `WAKE_IDX_STS5);
  assign hit_rsvd = idx_hit(wb_adr_i, `WAKE_IDX_RSVD);
  assign hit_en1 = idx_hit(wb_adr_i, `WAKE_IDX_EN1);

  // Read mux; the reserved slot holds no state
  assign rd_byte = hit_master ? {7'h00, master_q} :
                   hit_sts4 ? sts4 :
                   hit_sts5 ? sts5 :
                   hit_en1 ? en1_q :
                   `WAKE_RST_BYTE;

  // Write-one-to-clear masks, only at the edge where ack is seen
  assign clr4 = (byte0_wr & hit_sts4) ? wr_byte : 8'h00;
  assign clr5 = (byte0_wr & hit_sts5) ? wr_byte : 8'h00;

  // Next values of the read/write registers; reserved bits stay zero
  assign en1_d = (byte0_wr & hit_en1) ? (wr_byte & `WAKE_EN1_WMASK) : en1_q;
  assign master_d = (byte0_wr & hit_master) ? wr_byte[`WAKE_MASTER_BIT] : master_q;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      dat_q <= `WAKE_RST_WORD;
    end else begin
      ack_q <= take;
      if (take) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Enables live on the standby supply; srst is its power-on reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en1_q <= `WAKE_RST_BYTE;
      master_q <= 1'b0;
    end else begin
      en1_q <= en1_d;
      master_q <= master_d;
    end
  end

  // A source counts only if its enable and status are both set
  assign armed_one = en1_q & status_one_in;
  assign armed_four = enable_four_in & sts4;
  assign armed_five = enable_five_in & sts5;
  assign wake_pending = master_q & ((|armed_one) | (|armed_four) | (|armed_five));

  // Active-low request, registered so the pin never glitches
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      req_n_q <= 1'b1;
    end else begin
      req_n_q <= ~wake_pending;
    end
  end

  assign wake_request_n = req_n_q;

  // Request is answered exactly one cycle later
  ack_follows_a: assert property (@(posedge ref_clk) disable iff (srst)
    take |=> ack_q)
    else $error("ack did not follow request");

  // Ack lasts one cycle
  ack_single_a: assert property (@(posedge ref_clk) disable iff (srst)
    ack_q |=> !ack_q)
    else $error("ack held for more than one cycle");

  // Reserved slot and unmapped words read zero
  rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
    (take & !(hit_master | hit_sts4 | hit_sts5 | hit_en1)) |=> (dat_q == 32'h0000_0000))
    else $error("reserved offset returned non-zero data");

  // Status four reads back what the status byte holds
  sts4_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (take & hit_sts4) |=> (dat_q == {24'h00_0000, $past(sts4)}))
    else $error("status four read mismatch");

  // Enable one keeps only writable bits of a committed write
  en1_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_en1) |=> (en1_q == ($past(wr_byte) & 8'hFE)))
    else $error("enable one write not stored");

  // Enable one reserved bit never sets
  en1_rsvd_a: assert property (@(posedge ref_clk) disable iff (srst)
    !en1_q[0])
    else $error("enable one reserved bit set");

  // Enable one holds when not written
  en1_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(byte0_wr & hit_en1) |=> $stable(en1_q))
    else $error("enable one changed without a write");

  // Master enable follows bit 0 of a committed write
  master_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_master) |=> (master_q == $past(wr_byte[0])))
    else $error("master wake enable write not stored");

  // Enabled set status with master on drives the request low next cycle
  req_asserts_a: assert property (@(posedge ref_clk) disable iff (srst)
    (master_q & (((en1_q & status_one_in) | (enable_four_in & sts4)
      | (enable_five_in & sts5)) != 8'h00)) |=> !req_n_q)
    else $error("wake request not asserted");

  // Without master enable or any armed source the request is released
  req_releases_a: assert property (@(posedge ref_clk) disable iff (srst)
    (!master_q | (((en1_q & status_one_in) | (enable_four_in & sts4)
      | (enable_five_in & sts5)) == 8'h00)) |=> req_n_q)
    else $error("wake request driven without cause");

  // Request stays high through reset and right after it
  req_reset_a: assert property (@(posedge ref_clk)
    srst |=> req_n_q)
    else $error("wake request low after standby reset");

  // Ack is never raised without a taken request
  ack_after_take_a: assert property (@(posedge ref_clk) disable iff (srst)
    !take |=> !ack_q)
    else $error("ack raised without a taken request");

  // Reset leaves the bus quiet
  bus_reset_a: assert property (@(posedge ref_clk)
    srst |=> (!ack_q && (dat_q == 32'h0000_0000)))
    else $error("bus outputs not cleared by reset");

  // Read data stands until the next taken request
  dat_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !take |=> $stable(dat_q))
    else $error("read data changed without a request");

  // Only the low byte of read data ever carries a value
  dat_upper_a: assert property (@(posedge ref_clk) disable iff (srst)
    dat_q[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  // Status five reads back what the status byte holds
  sts5_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (take & hit_sts5) |=> (dat_q == {24'h00_0000, $past(sts5)}))
    else $error("status five read mismatch");

  // Enable one reads back its stored value
  en1_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (take & hit_en1) |=> (dat_q == {24'h00_0000, $past(en1_q)}))
    else $error("enable one read mismatch");

  // Master enable reads back in bit 0 with the rest zero
  master_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (take & hit_master) |=> (dat_q == {31'h0000_0000, $past(master_q)}))
    else $error("master wake enable read mismatch");

  // Master enable holds when not written
  master_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(byte0_wr & hit_master) |=> $stable(master_q))
    else $error("master wake enable changed without a write");

  // Standby reset empties enable one
  en1_reset_a: assert property (@(posedge ref_clk)
    srst |=> (en1_q == 8'h00))
    else $error("enable one not zero after standby reset");

  // Standby reset turns the master enable off
  master_reset_a: assert property (@(posedge ref_clk)
    srst |=> !master_q)
    else $error("master wake enable set after standby reset");

  // A write to the reserved slot changes no state
  rsvd_inert_a: assert property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_rsvd) |=> ($stable(en1_q) && $stable(master_q)
      && ((($past(sts4) & ~sts4) | ($past(sts5) & ~sts5)) == 8'h00)))
    else $error("reserved slot write changed state");

  // Write of one clears status four bits when no pin edge competes
  sts4_w1c_a: assert property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_sts4 & (pins_four_sync == 8'h00)) |=> ((sts4 & $past(wr_byte)) == 8'h00))
    else $error("status four not cleared by write of one");

  // Write of one clears status five bits when no pin edge competes
  sts5_w1c_a: assert property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_sts5 & (pins_five_sync == 8'h00)) |=> ((sts5 & $past(wr_byte)) == 8'h00))
    else $error("status five not cleared by write of one");

  // Status four bits written with zero stay set
  sts4_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_sts4) |=> ((sts4 & $past(sts4 & ~wr_byte)) == $past(sts4 & ~wr_byte)))
    else $error("status four bit lost on write of zero");

  // Status five bits written with zero stay set
  sts5_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_sts5) |=> ((sts5 & $past(sts5 & ~wr_byte)) == $past(sts5 & ~wr_byte)))
    else $error("status five bit lost on write of zero");

  // Status bits fall only through a committed write
  sts_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
    !commit_wr |=> ((($past(sts4) & ~sts4) | ($past(sts5) & ~sts5)) == 8'h00))
    else $error("status bit fell without a write");

  // Pins reach the status logic two flops late
  pin_sync_a: assert property (@(posedge ref_clk) disable iff (srst)
    (!$past(srst) && !$past(srst, 2))
      |-> (pins_sync == $past({wake_pins_five, wake_pins_four}, 2)))
    else $error("pins not delayed by two flops");

  // Request low only while the master enable was on
  req_master_a: assert property (@(posedge ref_clk) disable iff (srst)
    !req_n_q |-> $past(master_q))
    else $error("wake request without master enable");

  // With every enable clear the request stays released
  disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
    ((en1_q == 8'h00) & (enable_four_in == 8'h00) & (enable_five_in == 8'h00)) |=> req_n_q)
    else $error("disabled source drove the wake request");

  // Ring one enable with its status set raises the request
  ring_one_arms_a: assert property (@(posedge ref_clk) disable iff (srst)
    (master_q & en1_q[`WAKE_EN1_RING_ONE_BIT] & status_one_in[`WAKE_EN1_RING_ONE_BIT])
      |=> !req_n_q)
    else $error("ring one wake not requested");

  // An enabled status five source raises the request
  five_arms_a: assert property (@(posedge ref_clk) disable iff (srst)
    (master_q & ((enable_five_in & sts5) != 8'h00)) |=> !req_n_q)
    else $error("status five wake not requested");

  // Main scenarios
  wake_low_c: cover property (@(posedge ref_clk) disable iff (srst)
    $fell(req_n_q));

  sts_clear_c: cover property (@(posedge ref_clk) disable iff (srst)
    (byte0_wr & hit_sts5 & (wr_byte & sts5) != 8'h00));

  rsvd_read_c: cover property (@(posedge ref_clk) disable iff (srst)
    take & hit_rsvd & !wb_we_i);

  disabled_event_c: cover property (@(posedge ref_clk) disable iff (srst)
    (sts4 != 8'h00) & (enable_four_in == 8'h00) & req_n_q);
endmodule

// ===== wake_sink.sv
// Chipset-side model that counts wake requests seen on the active-low wake line
`timescale 1ns/1ps
module wake_sink (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wake_request_n,
  output int wake_count
);
  logic idle_q;

  // Counts each fall of the wake line as one wake request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      idle_q <= 1'b1;
      wake_count <= 0;
    end else begin
      idle_q <= wake_request_n;
      if (idle_q && !wake_request_n) begin
        wake_count <= wake_count + 1;
      end
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the wake status and enable register bank
`timescale 1ns/1ps
module testbench;
  import wake_pkg::*;
  logic ref_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 8'h00, pf = 8'h00, pv = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] di = 32'h0, dq, rd;
  reg_byte_t s1 = 8'h00, e4 = 8'h00, e5 = 8'h00;
  logic req_n;
  int wake_count, n_mismatch = 0, cmp_count = 0, cyc_n = 0;

  pme_wake_status_enable_regs u_dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di),
    .wb_dat_o(dq), .wb_ack_o(ack), .wake_pins_four(pf), .wake_pins_five(pv),
    .status_one_in(s1), .enable_four_in(e4), .enable_five_in(e5), .wake_request_n(req_n));
  wake_sink u_sink (.ref_clk(ref_clk), .srst(srst), .wake_request_n(req_n),
    .wake_count(wake_count));

  // Clock of 100 ns period
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // Timeout guard on the whole run
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 6000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // One classic Wishbone cycle; only the run's timeout ends the wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    di <= {24'h0, d};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rd = dq;
    cyc <= 0;
    stb <= 0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
    wb(0, a, 8'h00);
    chk(rd, {24'h0, e}, m);
  endtask

  task automatic wait_n(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // Reset values, access kinds, reserved slot, standby reset mid-run
  task automatic t_regs();
    rchk(8'h08, 8'h00, "master rst");
    rchk(8'h1C, 8'h00, "sts4 rst");
    rchk(8'h20, 8'h00, "sts5 rst");
    rchk(8'h28, 8'h00, "en1 rst");
    wb(1, 8'h28, 8'hFF);
    rchk(8'h28, 8'hFE, "en1 rw");
    sel <= 4'hE;
    wb(1, 8'h28, 8'h00);
    sel <= 4'hF;
    rchk(8'h28, 8'hFE, "sel ignored");
    wb(1, 8'h08, 8'hFF);
    rchk(8'h08, 8'h01, "master rw");
    wb(1, 8'h24, 8'hFF);
    rchk(8'h24, 8'h00, "reserved");
    @(posedge ref_clk) srst <= 1;
    wait_n(3);
    @(posedge ref_clk) srst <= 0;
    rchk(8'h28, 8'h00, "en1 srst");
    rchk(8'h08, 8'h00, "master srst");
    $display("test regs done");
  endtask

  // Each pin sets its own bit, sticky, write-one clears, enables ignored
  task automatic t_status();
    logic [7:0] m, a;
    // Master on, so only the cleared enables keep the request off
    wb(1, 8'h08, 8'h01);
    for (int i = 0; i < 16; i++) begin
      m = 8'h01 << (i % 8);
      a = (i < 8) ? 8'h1C : 8'h20;
      @(posedge ref_clk);
      if (i < 8) pf <= m;
      else pv <= m;
      wait_n(4);
      @(posedge ref_clk) begin
        pf <= 8'h00;
        pv <= 8'h00;
      end
      wait_n(3);
      rchk(a, m, "status set");
      chk(req_n, 1, "disabled req");
      wb(1, a, ~m);
      rchk(a, m, "write zero");
      wb(1, a, m);
      rchk(a, 8'h00, "write one");
    end
    $display("test status done");
  endtask

  // Request needs enable, status and master on the same source
  task automatic t_request();
    wb(1, 8'h08, 8'h01);
    e5 <= 8'h80;
    @(posedge ref_clk) pv <= 8'h01;
    wait_n(6);
    chk(req_n, 1, "other source");
    @(posedge ref_clk) e5 <= 8'h01;
    wait_n(2);
    chk(req_n, 0, "request on");
    wb(1, 8'h08, 8'h00);
    wait_n(2);
    chk(req_n, 1, "master off");
    wb(1, 8'h08, 8'h01);
    wait_n(2);
    chk(req_n, 0, "master on");
    wb(1, 8'h20, 8'h01);
    wait_n(2);
    chk(req_n, 1, "cleared");
    pv <= 8'h00;
    s1 <= 8'h04;
    wb(1, 8'h28, 8'h04);
    wait_n(2);
    chk(req_n, 0, "en1 ring one");
    wb(1, 8'h28, 8'h02);
    wait_n(2);
    chk(req_n, 1, "en1 ring two");
    s1 <= 8'h00;
    e4 <= 8'h20;
    @(posedge ref_clk) pf <= 8'h20;
    wait_n(6);
    chk(req_n, 0, "four enabled");
    wb(1, 8'h1C, 8'h20);
    wait_n(2);
    chk(req_n, 1, "four cleared");
    pf <= 8'h00;
    chk(wake_count, 4, "sink count");
    $display("test request done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    wait_n(20);
    @(posedge ref_clk) srst <= 0;
    t_regs();
    t_status();
    t_request();
    close_out();
  end
endmodule
